// File: ams_cfg.svh
// Constants of the acquisition memory sequencer.
// Assumes inclusion by ams_pkg.sv and ams_sequencer.sv only.
`ifndef AMS_CFG_SVH
`define AMS_CFG_SVH
`define AMS_DATA_W 16
`define AMS_ADDR_W 20
`define AMS_MEM_WORDS 21'h100000
`define AMS_REP_WORDS 21'h080000
`define AMS_GATE_ONE_LEN 21'h080000
`define AMS_MAX_BLOCKS 9'h100
`define AMS_MAX_BLOCK_LOG 4'h8
`define AMS_MIN_REC 21'h000064
`define AMS_PRE_GAP 21'h000002
`define AMS_LINK_DIV 21'h00000A
`define AMS_CLK_NS 25
`define AMS_STEP_NS 10000
`define AMS_STEP_CYC 9'((`AMS_STEP_NS + `AMS_CLK_NS - 1) / `AMS_CLK_NS)
`define AMS_MAX_IVL_US 10000000
`define AMS_STEP_US 10
`define AMS_MAX_STEPS 20'(`AMS_MAX_IVL_US / `AMS_STEP_US)
`define AMS_LINK_MIN_US 100
`define AMS_LINK_MIN_STEPS 20'(`AMS_LINK_MIN_US / `AMS_STEP_US)
`define AMS_FREE_MIN_US 1000
`define AMS_FREE_MIN_STEPS 20'(`AMS_FREE_MIN_US / `AMS_STEP_US)
`define AMS_FREE_LINK_US 10000
`define AMS_FREE_LINK_STEPS 20'(`AMS_FREE_LINK_US / `AMS_STEP_US)
`define AMS_FIFO_DEPTH 16
`endif

// File: ams_partner.sv
// Converter front end and acquisition memory model facing the sequencer.
// Assumes the sequencer's clock and reset, and ams_pkg compiled first.
`timescale 1ns/1ps
`default_nettype none
module ams_partner (
  input wire logic clk,
  input wire logic reset,
  input wire logic conv_start,
  input wire logic [3:0] chans,
  input wire logic adc_ready,
  output logic adc_valid,
  output logic [15:0] adc_data,
  input wire ams_pkg::ams_mem_wr_t mem,
  input wire logic stall,
  output logic mem_ready
);
  import ams_pkg::*;
  int made;
  int sent;
  logic [15:0] last;
  logic [19:0] wa [$];
  logic [15:0] wd [$];
  assign adc_valid = made != sent;
  // Released data line shows the inverse of the last word
  assign adc_data = adc_valid ? (16'(sent) ^ 16'hA5C3) : ~last;
  always @(posedge clk) begin
    if (reset) begin
      made <= 0;
      sent <= 0;
      last <= 16'h0000;
      mem_ready <= 1'b0;
      wa.delete();
      wd.delete();
    end else begin
      if (conv_start) made <= made + int'(chans);
      if (adc_valid && adc_ready) begin
        sent <= sent + 1;
        last <= adc_data;
      end
      mem_ready <= !stall && ($urandom_range(3) != 0);
      if (mem.we && mem_ready) begin
        wa.push_back(mem.addr);
        wd.push_back(mem.data);
      end
    end
  end
endmodule
`default_nettype wire

// File: ams_pkg.sv
// Types of the acquisition memory sequencer.
// Assumes ams_cfg.svh is on the include path.
`include "ams_cfg.svh"
package ams_pkg;
  typedef enum logic [1:0] {
    MODE_TRIG = 2'h0,
    MODE_FREE = 2'h1,
    MODE_GATE = 2'h2
  } ams_mode_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ARMED = 6'h02,
    ST_POST = 6'h04,
    ST_FREE = 6'h08,
    ST_GWAIT = 6'h10,
    ST_GCAP = 6'h20
  } ams_state_t;

  typedef struct packed {
    ams_mode_t mode;
    logic repeat_en;
    logic [3:0] chans;
    logic [20:0] rec_len;
    logic [15:0] acq_count;
    logic [7:0] block_sel;
    logic [20:0] pretrig;
    logic [19:0] interval;
    logic linked;
    logic filter_on;
    logic external_timebase_select;
  } ams_cfg_t;

  typedef struct packed {
    logic we;
    logic [`AMS_ADDR_W-1:0] addr;
    logic [`AMS_DATA_W-1:0] data;
  } ams_mem_wr_t;
endpackage

// File: ams_sequencer.sv
// Acquisition memory sequencer with its sample FIFO.
// Assumes converter words arrive on the I_CLK domain, one word per channel per tick,
// and the trigger condition arrives already evaluated on I_CLK.
//
// Contract
// - Triggered mode captures record, then halts
// - Triggered blocks filled in order, one per trigger
// - Block count is power-of-two fit, max 256
// - Repeat only if blocks at least twice count
// - Repeat restarts sequence until next start
// - Free run starts and stops on start
// - Gated stores while trigger holds, length-limited
// - Gated repeats count times, stops at once
// - Triggered/gated interval limits in 10 us steps
// - Free-run interval limits 1 ms to 10 s
// - Stopped partitioned capture marks block invalid
// - Triggered record length 100 to capacity
// - Repeat halves capacity, linked takes tenth
// - Zero triggered length uses full capacity
// - Zero gated length follows gate duration
// - Count 1 to 32768, zero overwrites forever
// - Triggered count beyond blocks wraps around
// - Gated short records keep 256, then wrap
// - Gated huge records force count one
// - Gated oversize keeps last fitting blocks
// - Internal interval or shared time base line
// - Pre-trigger points zero to length minus two
`include "ams_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module ams_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic rdy;
  } ams_fifo_st_t;
  logic [WIDTH-1:0] mem [DEPTH];
  ams_fifo_st_t r, n;
  logic push, pop;

  assign push = in_valid && r.rdy;
  assign pop = out_valid && out_ready;
  assign out_valid = r.cnt != '0;
  assign out_data = mem[r.rp];
  assign in_ready = r.rdy;

  always_comb begin
    n = r;
    if (push) n.wp = r.wp + 1'b1;
    if (pop) n.rp = r.rp + 1'b1;
    n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    n.rdy = n.cnt != (AW+1)'(DEPTH);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r <= '0;
      r.rdy <= 1'b1;
    end else begin
      r <= n;
    end
    if (push) mem[r.wp] <= in_data;
  end
endmodule

module ams_sequencer (
  input wire logic I_CLK,
  input wire logic I_RESET,
  input wire ams_pkg::ams_cfg_t I_CFG,
  input wire logic I_START,
  input wire logic I_TRIG,
  input wire logic I_SHARED_TIMEBASE_LINE,
  output logic O_CONV_START,
  input wire logic I_ADC_VALID,
  input wire logic [`AMS_DATA_W-1:0] I_ADC_DATA,
  output logic O_ADC_READY,
  output ams_pkg::ams_mem_wr_t O_MEM,
  input wire logic I_MEM_READY,
  output logic O_BUSY,
  output logic [8:0] O_BLOCK_COUNT,
  output logic [8:0] O_CUR_BLOCK,
  output logic [20:0] O_REC_LEN_EFF,
  output logic [15:0] O_ACQ_DONE,
  output logic O_REPEAT_OK,
  output logic [19:0] O_TRIG_ADDR,
  output logic O_INVALID,
  output logic [8:0] O_INVALID_BLOCK
);
  import ams_pkg::*;

  typedef struct packed {
    ams_state_t st;
    logic [8:0] cyc;
    logic [19:0] stp;
    logic tick;
    logic [3:0] wip;
    logic [20:0] pts;
    logic [20:0] wofs;
    logic [8:0] blk;
    logic [8:0] start_blk;
    logic [15:0] acq_done;
    logic [8:0] gblk;
    logic [20:0] base;
    ams_mem_wr_t mem;
    logic [19:0] trig_addr;
    logic invalid;
    logic [8:0] inv_blk;
    logic [2:0] sync;
    logic tb_lvl;
    logic [8:0] blocks;
    logic [3:0] blog;
    logic [20:0] eff_len;
    logic [20:0] pre;
    logic rep_ok;
    logic [19:0] ivl;
    logic [15:0] acq_eff;
    logic [8:0] gate_lim;
    logic [24:0] recw;
    logic busy;
  } ams_seq_st_t;

  ams_seq_st_t r, n;
  logic f_valid, f_ready, pop;
  logic [`AMS_DATA_W-1:0] f_data;

  assign f_ready = !r.mem.we || I_MEM_READY;
  assign pop = f_valid && f_ready;

  ams_fifo #(
    .WIDTH(`AMS_DATA_W),
    .DEPTH(`AMS_FIFO_DEPTH)
  ) u_fifo (
    .clk(I_CLK),
    .reset(I_RESET),
    .in_valid(I_ADC_VALID),
    .in_ready(O_ADC_READY),
    .in_data(I_ADC_DATA),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  always_comb begin
    logic [24:0] prod;
    logic [20:0] len, mx, minl;
    logic [19:0] mins;
    logic [8:0] bl;
    logic [3:0] lg;
    logic tb_rise, step_end, pt_start, last_w, wr, fin, gate_end;
    logic [19:0] cur;
    prod = '0;
    len = '0;
    mx = '0;
    minl = '0;
    mins = '0;
    bl = 9'h001;
    lg = 4'h0;
    tb_rise = 1'b0;
    step_end = 1'b0;
    pt_start = 1'b0;
    last_w = 1'b0;
    wr = 1'b0;
    fin = 1'b0;
    gate_end = 1'b0;
    cur = 20'(r.base + r.wofs);
    n = r;
    n.tick = 1'b0;
    if (r.mem.we && I_MEM_READY) n.mem.we = 1'b0;

    // Settings evaluated every cycle into registers
    prod = 25'(I_CFG.rec_len) * 25'(I_CFG.chans);
    for (int k = 0; k <= 8; k++) begin
      if (prod != '0 && (prod << k) <= 25'(`AMS_MEM_WORDS)) begin
        bl = 9'(1 << k);
        lg = 4'(k);
      end
    end
    if (I_CFG.mode != MODE_TRIG) begin
      bl = 9'h001;
      lg = 4'h0;
    end
    n.blocks = bl;
    n.blog = lg;
    n.rep_ok = I_CFG.repeat_en && I_CFG.mode == MODE_TRIG && I_CFG.acq_count != '0 &&
               {7'h00, bl} >= {I_CFG.acq_count[14:0], 1'b0} && !I_CFG.acq_count[15];
    mx = (n.rep_ok ? `AMS_REP_WORDS : `AMS_MEM_WORDS) >> lg;
    mx = mx / 21'(I_CFG.chans);
    if (I_CFG.linked) mx = mx / `AMS_LINK_DIV;
    len = I_CFG.rec_len;
    if (I_CFG.mode == MODE_TRIG) begin
      if (len == '0) len = mx;
      else if (len < `AMS_MIN_REC) len = `AMS_MIN_REC;
      else if (len > mx) len = mx;
    end
    n.eff_len = len;
    n.recw = 25'(len) * 25'(I_CFG.chans);
    n.pre = (I_CFG.pretrig > len - `AMS_PRE_GAP) ? len - `AMS_PRE_GAP : I_CFG.pretrig;
    n.acq_eff = I_CFG.acq_count;
    if (I_CFG.mode == MODE_GATE && len >= `AMS_GATE_ONE_LEN) n.acq_eff = 16'h0001;
    n.gate_lim = `AMS_MAX_BLOCKS;
    if (len != '0 && n.recw <= 25'(`AMS_MEM_WORDS) &&
        25'(`AMS_MEM_WORDS) / n.recw < 25'(`AMS_MAX_BLOCKS)) begin
      n.gate_lim = 9'(25'(`AMS_MEM_WORDS) / n.recw);
    end
    if (I_CFG.mode == MODE_FREE) begin
      mins = `AMS_FREE_MIN_STEPS;
      if (I_CFG.filter_on) begin
        mins = I_CFG.linked ? `AMS_FREE_LINK_STEPS : 20'(`AMS_FREE_MIN_STEPS * I_CFG.chans);
      end
    end else begin
      mins = I_CFG.filter_on ? 20'h00001 : 20'(I_CFG.chans);
      if (I_CFG.linked && mins < `AMS_LINK_MIN_STEPS) mins = `AMS_LINK_MIN_STEPS;
    end
    n.ivl = I_CFG.interval;
    if (n.ivl < mins) n.ivl = mins;
    if (n.ivl > `AMS_MAX_STEPS) n.ivl = `AMS_MAX_STEPS;

    // Sampling time base
    n.sync = {r.sync[1:0], I_SHARED_TIMEBASE_LINE};
    if (r.sync[1] == r.sync[2]) n.tb_lvl = r.sync[2];
    tb_rise = r.sync[1] == r.sync[2] && r.sync[2] && !r.tb_lvl;
    if (r.st != ST_IDLE) begin
      n.cyc = (r.cyc == `AMS_STEP_CYC - 9'h001) ? 9'h000 : r.cyc + 9'h001;
      step_end = r.cyc == `AMS_STEP_CYC - 9'h001;
      if (step_end) n.stp = (r.stp >= r.ivl - 20'h00001) ? 20'h00000 : r.stp + 20'h00001;
      n.tick = I_CFG.external_timebase_select ? tb_rise :
               (step_end && r.stp >= r.ivl - 20'h00001);
    end

    // Sample words from the FIFO
    if (pop && r.st != ST_IDLE) begin
      pt_start = r.wip == 4'h0;
      last_w = r.wip == I_CFG.chans - 4'h1;
      n.wip = last_w ? 4'h0 : r.wip + 4'h1;
      unique case (r.st)
        ST_ARMED: begin
          wr = 1'b1;
          if (pt_start && I_TRIG && r.pts >= r.pre) begin
            n.st = ST_POST;
            n.pts = '0;
            n.trig_addr = cur;
          end
        end
        ST_POST: wr = 1'b1;
        ST_FREE: wr = 1'b1;
        ST_GWAIT: begin
          if (pt_start && I_TRIG) begin
            n.st = ST_GCAP;
            n.pts = '0;
            wr = 1'b1;
          end
        end
        ST_GCAP: begin
          if (pt_start && (!I_TRIG || (r.eff_len != '0 && r.pts == r.eff_len))) begin
            gate_end = 1'b1;
          end else begin
            wr = 1'b1;
          end
        end
        default: ;
      endcase
      if (wr) begin
        n.mem = '{we: 1'b1, addr: cur, data: f_data};
        n.wofs = r.wofs + 21'h000001;
        // Ring stays inside the block through the post-trigger part too
        if ((r.st == ST_ARMED || r.st == ST_POST) && 25'(n.wofs) == r.recw) n.wofs = '0;
        if (last_w && !(n.st == ST_ARMED && n.pts >= r.pre)) n.pts = n.pts + 21'h000001;
      end
      if (wr && last_w && n.st == ST_POST && n.pts == r.eff_len - r.pre) begin
        fin = r.acq_eff != '0 && r.acq_done + 16'h0001 == r.acq_eff;
        n.acq_done = r.acq_done + 16'h0001;
        n.pts = '0;
        n.wofs = '0;
        n.st = ST_ARMED;
        n.blk = (r.blk + 9'h001) & (r.blocks - 9'h001);
        if (fin && !r.rep_ok) begin
          n.st = ST_IDLE;
        end else if (fin) begin
          n.acq_done = '0;
          n.blk = r.start_blk;
        end
        n.base = 21'(n.blk) << (`AMS_ADDR_W - 32'(r.blog));
      end
      if (gate_end) begin
        fin = r.acq_eff != '0 && r.acq_done + 16'h0001 == r.acq_eff;
        n.acq_done = r.acq_done + 16'h0001;
        n.gblk = r.gblk + 9'h001;
        n.base = 21'(r.base + r.wofs);
        if (n.gblk == r.gate_lim || (r.eff_len != '0 &&
            25'(n.base) + r.recw > 25'(`AMS_MEM_WORDS))) begin
          n.gblk = '0;
          n.base = '0;
        end
        n.blk = n.gblk;
        n.wofs = '0;
        n.pts = '0;
        n.st = fin ? ST_IDLE : ST_GWAIT;
      end
    end

    // Start and stop commands
    if (I_START) begin
      if (r.st == ST_IDLE) begin
        n.invalid = 1'b0;
        n.acq_done = '0;
        n.pts = '0;
        n.wofs = '0;
        n.wip = '0;
        n.gblk = '0;
        n.cyc = '0;
        n.stp = '0;
        n.blk = '0;
        if (r.acq_eff != '0 && {1'b0, r.acq_eff} < {8'h00, r.blocks}) begin
          n.blk = 9'(I_CFG.block_sel) & (r.blocks - 9'h001);
        end
        n.start_blk = n.blk;
        n.base = 21'(n.blk) << (`AMS_ADDR_W - 32'(r.blog));
        unique case (I_CFG.mode)
          MODE_FREE: n.st = ST_FREE;
          MODE_GATE: n.st = ST_GWAIT;
          default: n.st = ST_ARMED;
        endcase
      end else begin
        n.st = ST_IDLE;
        if ((r.st == ST_ARMED || r.st == ST_POST) && r.blocks != 9'h001 &&
            (r.acq_eff == '0 || r.acq_done < r.acq_eff)) begin
          n.invalid = 1'b1;
          n.inv_blk = r.blk;
        end
      end
    end
    n.busy = n.st != ST_IDLE;
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      r <= '0;
      r.st <= ST_IDLE;
      r.blocks <= 9'h001;
    end else begin
      r <= n;
    end
  end

  assign O_CONV_START = r.tick;
  assign O_MEM = r.mem;
  assign O_BUSY = r.busy;
  assign O_BLOCK_COUNT = r.blocks;
  assign O_CUR_BLOCK = r.blk;
  assign O_REC_LEN_EFF = r.eff_len;
  assign O_ACQ_DONE = r.acq_done;
  assign O_REPEAT_OK = r.rep_ok;
  assign O_TRIG_ADDR = r.trig_addr;
  assign O_INVALID = r.invalid;
  assign O_INVALID_BLOCK = r.inv_blk;

  a_free_start_go: assert property (@(posedge I_CLK) disable iff (I_RESET)
    r.st == ST_IDLE && I_START && I_CFG.mode == MODE_FREE |=> r.st == ST_FREE)
    else $error("free run did not start");
  a_free_stop_go: assert property (@(posedge I_CLK) disable iff (I_RESET)
    r.st == ST_FREE && I_START |=> r.st == ST_IDLE ##1 !r.mem.we || r.mem == $past(r.mem))
    else $error("free run kept storing after stop");
  a_block_pow_two: assert property (@(posedge I_CLK) disable iff (I_RESET)
    $onehot(r.blocks) && r.blocks <= `AMS_MAX_BLOCKS)
    else $error("block count not a power of two up to 256");
  a_repeat_allow_cond: assert property (@(posedge I_CLK) disable iff (I_RESET)
    r.rep_ok |-> $past(I_CFG.acq_count) != '0 && $past(I_CFG.repeat_en))
    else $error("repeat allowed without count or request");
  a_gate_store_only: assert property (@(posedge I_CLK) disable iff (I_RESET)
    $rose(r.mem.we) && $past(r.st) != ST_ARMED && $past(r.st) != ST_POST &&
    $past(r.st) != ST_FREE |-> $past(I_TRIG) || $past(r.wip) != 4'h0)
    else $error("gated store without trigger condition");
  a_tick_spacing_min: assert property (@(posedge I_CLK) disable iff (I_RESET)
    r.tick && !I_CFG.external_timebase_select |=> !r.tick [*8])
    else $error("internal sampling ticks too close");
  a_trig_len_min: assert property (@(posedge I_CLK) disable iff (I_RESET)
    r.st == ST_POST |-> r.eff_len >= `AMS_MIN_REC || I_CFG.mode != MODE_TRIG)
    else $error("triggered record shorter than minimum");
  a_addr_in_block: assert property (@(posedge I_CLK) disable iff (I_RESET)
    r.mem.we && $past(r.st) == ST_POST && r.st == ST_POST && r.blocks != 9'h001 |->
    (r.mem.addr >> (`AMS_ADDR_W - 32'(r.blog))) == 20'(r.blk))
    else $error("write outside active block");
  a_invalid_on_stop: assert property (@(posedge I_CLK) disable iff (I_RESET)
    $rose(r.invalid) |-> $past(I_START) && $past(r.st) != ST_IDLE &&
    r.inv_blk == $past(r.blk))
    else $error("invalid block flag without stop");
  a_pretrig_bound: assert property (@(posedge I_CLK) disable iff (I_RESET)
    r.st == ST_POST && r.eff_len >= `AMS_MIN_REC |-> r.pre <= r.eff_len - `AMS_PRE_GAP)
    else $error("pre-trigger exceeds length minus two");
endmodule

`default_nettype wire

// File: ams_sequencer_test.sv
// Self-checking bench of the acquisition memory sequencer.
// Assumes ams_pkg, ams_sequencer.sv and ams_partner.sv compiled first.
`timescale 1ns/1ps
`default_nettype none
module ams_sequencer_test;
  import ams_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic trig = 1'b0;
  logic tb_line = 1'b0;
  logic stall = 1'b0;
  ams_cfg_t cfg;
  logic conv, adc_valid, adc_ready, mem_ready, busy, rep_ok, inval;
  logic [15:0] adc_data, acq_done;
  ams_mem_wr_t mem;
  logic [8:0] blk_cnt, cur_blk, inval_blk;
  logic [20:0] len_eff;
  logic [19:0] trig_addr;
  int err_total = 0;
  int n_checks = 0;
  int tc[4] = '{8, 8, 1, 10};
  int tl[4] = '{1000, 1000, 100, 0};
  int tn[4] = '{64, 65, 0, 1};
  int c, len, cnt, b, n, t0, rp, e;

  always #12.5 clk = ~clk;

  ams_sequencer i_ams_sequencer (.I_CLK(clk), .I_RESET(rst), .I_CFG(cfg), .I_START(start),
    .I_TRIG(trig), .I_SHARED_TIMEBASE_LINE(tb_line), .O_CONV_START(conv),
    .I_ADC_VALID(adc_valid), .I_ADC_DATA(adc_data), .O_ADC_READY(adc_ready), .O_MEM(mem),
    .I_MEM_READY(mem_ready), .O_BUSY(busy), .O_BLOCK_COUNT(blk_cnt), .O_CUR_BLOCK(cur_blk),
    .O_REC_LEN_EFF(len_eff), .O_ACQ_DONE(acq_done), .O_REPEAT_OK(rep_ok),
    .O_TRIG_ADDR(trig_addr), .O_INVALID(inval), .O_INVALID_BLOCK(inval_blk));

  ams_partner i_ams_partner (.clk(clk), .reset(rst), .conv_start(conv), .chans(cfg.chans),
    .adc_ready(adc_ready), .adc_valid(adc_valid), .adc_data(adc_data), .mem(mem),
    .stall(stall), .mem_ready(mem_ready));

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("Checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cyc(int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic do_reset();
    rst = 1'b1;
    cyc(20);
    rst = 1'b0;
    cyc(2);
  endtask

  task automatic pulse();
    start = 1'b1;
    cyc(1);
    start = 1'b0;
    cyc(1);
  endtask

  task automatic ticks(int k, int gap);
    repeat (k) begin
      tb_line = 1'b1;
      cyc(gap / 2);
      tb_line = 1'b0;
      cyc(gap - gap / 2);
    end
  endtask

  function automatic int wsz();
    return i_ams_partner.wa.size();
  endfunction

  task automatic wait_wr(int k);
    for (int i = 0; i < 20000 && wsz() < k; i++) cyc(1);
    if (wsz() < k) begin
      err_total++;
      give_verdict();
    end
  endtask

  task automatic setup(ams_mode_t m, int ch, int ln, int ct);
    cfg = '0;
    cfg.mode = m;
    cfg.chans = 4'(ch);
    cfg.rec_len = 21'(ln);
    cfg.acq_count = 16'(ct);
    cfg.interval = 20'h00001;
    cfg.block_sel = 8'h00;
    cfg.external_timebase_select = 1'b1;
    do_reset();
  endtask

  function automatic int exp_blocks(int ch, int ln);
    int q;
    int r;
    q = 1048576 / (ch * ln);
    r = 1;
    while (r * 2 <= q && r < 256) r = r * 2;
    return r;
  endfunction

  initial begin
    cfg = '0;
    cfg.chans = 4'h1;
    void'($urandom(70541));
    cyc(20);
    check("busy", busy, 0);
    check("blocks", blk_cnt, 1);
    check("adc_ready", adc_ready, 1);
    rst = 1'b0;
    cyc(2);
    cfg.repeat_en = 1'b1;
    for (int k = 0; k < 28; k++) begin
      c = (k < 4) ? tc[k] : $urandom_range(1, 10);
      len = (k < 4) ? tl[k] : $urandom_range(100, 20000);
      cnt = (k < 4) ? tn[k] : $urandom_range(0, 300);
      cfg.chans = 4'(c);
      cfg.rec_len = 21'(len);
      cfg.acq_count = 16'(cnt);
      cyc(2);
      b = (len == 0) ? 1 : exp_blocks(c, len);
      check("blocks", blk_cnt, b);
      rp = (cnt != 0) && (b >= 2 * cnt);
      e = (len == 0) ? 1048576 / c / b : len;
      if (rp && e > 524288 / b / c) e = 524288 / b / c;
      check("repeat_ok", rep_ok, rp);
      check("len_eff", len_eff, e);
    end
    // Internal timebase at two steps
    setup(MODE_TRIG, 1, 100, 1);
    cfg.external_timebase_select = 1'b0;
    cfg.interval = 20'h00002;
    cyc(2);
    pulse();
    n = 0;
    for (int i = 0; i < 3000 && n < 3; i++) begin
      cyc(1);
      if (conv) begin
        if (n == 1) t0 = i;
        if (n == 2) check("tick_gap", i - t0, 800);
        n++;
      end
    end
    check("tick_seen", n, 3);
    pulse();
    // Free run with the memory stalled until the buffer refuses
    setup(MODE_FREE, 2, 0, 0);
    stall = 1'b1;
    pulse();
    ticks(10, 40);
    check("fifo_full", adc_ready, 0);
    stall = 1'b0;
    wait_wr(20);
    for (int k = 0; k < 20; k++) begin
      check("fr_addr", i_ams_partner.wa[k], k);
      check("fr_data", i_ams_partner.wd[k], k ^ 16'hA5C3);
    end
    check("fifo_empty", adc_ready, 1);
    pulse();
    ticks(3, 40);
    check("fr_stop", busy, 0);
    check("fr_count", wsz(), 20);
    // Gated, length from gate, two captures
    setup(MODE_GATE, 1, 0, 2);
    pulse();
    trig = 1'b1;
    ticks(4, 40);
    trig = 1'b0;
    ticks(2, 40);
    trig = 1'b1;
    ticks(2, 40);
    trig = 1'b0;
    // Gate close is seen at the next sample
    ticks(1, 40);
    cyc(40);
    check("gate_wr", wsz(), 6);
    check("gate_busy", busy, 0);
    check("gate_done", acq_done, 2);
    trig = 1'b1;
    ticks(2, 40);
    check("gate_after", wsz(), 6);
    // Gated, record length ends the block early
    setup(MODE_GATE, 1, 3, 1);
    pulse();
    ticks(5, 40);
    trig = 1'b0;
    cyc(40);
    check("gate_len", wsz(), 3);
    check("gate_len_busy", busy, 0);
    // Gated, stopped mid count
    setup(MODE_GATE, 1, 0, 3);
    pulse();
    trig = 1'b1;
    ticks(2, 40);
    pulse();
    ticks(2, 40);
    check("gate_stop", wsz(), 2);
    check("gate_stop_busy", busy, 0);
    // Triggered, two blocks then halt
    setup(MODE_TRIG, 1, 100, 2);
    pulse();
    ticks(205, 20);
    wait_wr(200);
    cyc(40);
    check("trig_wr", wsz(), 200);
    check("trig_busy", busy, 0);
    check("trig_done", acq_done, 2);
    check("trig_a99", i_ams_partner.wa[99], 99);
    check("trig_a100", i_ams_partner.wa[100], 4096);
    check("trig_addr", trig_addr, 4096);
    check("cur_blk", cur_blk, 2);
    // Triggered, stopped inside the second block
    setup(MODE_TRIG, 1, 100, 3);
    pulse();
    ticks(150, 20);
    pulse();
    check("inv", inval, 1);
    check("inv_blk", inval_blk, 1);
    check("inv_busy", busy, 0);
    trig = 1'b0;
    give_verdict();
  end
endmodule
`default_nettype wire
